// file: common/adc_regs.svh
// timing counts and widths of the dram strobe controller
// assumes a single 100 MHz clock; every time is in ns and rounded to cycles here
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

`define ADC_CLK_NS        10
`define ADC_CYC_UP(ns)    (((ns) + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_CYC_DN(ns)    ((ns) / `ADC_CLK_NS)

// power-up pause, idle limit and refresh spacing
`define ADC_PAUSE_NS      200000
`define ADC_IDLE_NS       32000000
`define ADC_REF_NS        15625
`define ADC_INIT_RAS      8

// strobe timing defaults, each a least time
`define ADC_T_ASR_NS      10
`define ADC_T_RCD_NS      20
`define ADC_T_CAS_NS      40
`define ADC_T_CP_NS       10
`define ADC_T_RP_NS       40
`define ADC_T_RAS_NS      60
`define ADC_T_CSR_NS      10

// widths
`define ADC_ROW_W         11
`define ADC_COL_W         11
`define ADC_PIN_A_W       12
`define ADC_DATA_W        128
`define ADC_CHK_W         16
`define ADC_TMR_W         22
`define ADC_CNT_INIT_W    4

`endif

// file: common/adc_pkg.sv
// types shared by the dram strobe controller and its timer
// assumes adc_regs.svh is on the include path
`include "adc_regs.svh"

package adc_pkg;

  typedef struct packed {
    logic                    write;
    logic                    bank;
    logic [`ADC_ROW_W-1:0]   row;
    logic [`ADC_COL_W-1:0]   col;
    logic [`ADC_DATA_W-1:0]  data;
    logic [`ADC_CHK_W-1:0]   check_bits;
  } adc_req_t;

  typedef struct packed {
    logic [`ADC_DATA_W-1:0]  data;
    logic [`ADC_CHK_W-1:0]   check_bits;
  } adc_rsp_t;

  typedef struct packed {
    logic                    ras_n;
    logic                    cas_n;
    logic                    we_n;
    logic [1:0]              bank_n;
    logic [`ADC_PIN_A_W-1:0] addr;
  } adc_pins_t;

  typedef enum logic [1:0] {
    ADC_REF_ROW_ONLY,
    ADC_REF_CAS_FIRST,
    ADC_REF_HIDDEN
  } adc_ref_mode_t;

  typedef enum logic [3:0] {
    S_BOOT,
    S_PAUSE,
    S_IDLE,
    S_ROW,
    S_RCD,
    S_COL,
    S_CAS,
    S_CAS_UP,
    S_PRE,
    S_ROR_SET,
    S_ROR_RAS,
    S_CBR_CAS,
    S_CBR_RAS,
    S_HID_PRE,
    S_HID_RAS
  } adc_state_t;

endpackage

// file: verilog/adc_tmr.sv
// down counter that times every strobe phase of the controller
// assumes load_i is a one-cycle pulse from the same clock
`include "adc_regs.svh"

module adc_tmr
  import adc_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  // load
  input  wire logic                  load_i,
  input  wire logic [`ADC_TMR_W-1:0] value_i,
  // status
  output logic                       done_o
);

  logic [`ADC_TMR_W-1:0] cnt;
  logic [`ADC_TMR_W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (load_i) begin
      next_cnt = value_i;
    end else if (cnt != '0) begin
      next_cnt = cnt - `ADC_TMR_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // done looks at the count alone: gating it with load_i would close a zero-delay
  // loop through the state decode, which reads done and drives load
  assign done_o = (cnt == '0);

endmodule

// file: verilog/adc_ctrl.sv
// controller that drives an asynchronous multiplexed-address dram module by its pins
// assumes the module's data pins are outside this clock domain and a user port on clk_i
`include "adc_regs.svh"
module adc_ctrl
  import adc_pkg::*;
#(
  parameter int unsigned PAUSE_CYC = `ADC_CYC_UP(`ADC_PAUSE_NS),
  parameter int unsigned IDLE_CYC  = `ADC_CYC_DN(`ADC_IDLE_NS),
  parameter int unsigned REF_CYC   = `ADC_CYC_DN(`ADC_REF_NS),
  parameter int unsigned T_ASR     = `ADC_CYC_UP(`ADC_T_ASR_NS),
  parameter int unsigned T_RCD     = `ADC_CYC_UP(`ADC_T_RCD_NS),
  parameter int unsigned T_CAS     = `ADC_CYC_UP(`ADC_T_CAS_NS),
  parameter int unsigned T_CP      = `ADC_CYC_UP(`ADC_T_CP_NS),
  parameter int unsigned T_RP      = `ADC_CYC_UP(`ADC_T_RP_NS),
  parameter int unsigned T_RAS     = `ADC_CYC_UP(`ADC_T_RAS_NS),
  parameter int unsigned T_CSR     = `ADC_CYC_UP(`ADC_T_CSR_NS)
)
(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  // user request
  input  wire logic                   req_valid_i,
  output logic                        req_ready_o,
  input  wire adc_req_t               req_i,
  input  wire logic                   page_en_i,
  // user read answer
  output logic                        rd_valid_o,
  output adc_rsp_t                    rd_o,
  // refresh control and status
  input  wire logic                   refresh_en_i,
  input  wire adc_ref_mode_t          refresh_mode_i,
  output logic                        init_done_o,
  // dram strobes and address
  output adc_pins_t                   dram_o,
  // dram data pins
  input  wire logic [`ADC_DATA_W-1:0] data_i,
  output logic      [`ADC_DATA_W-1:0] data_o,
  output logic                        data_oe_o,
  input  wire logic [`ADC_CHK_W-1:0]  check_bits_i,
  output logic      [`ADC_CHK_W-1:0]  check_bits_o,
  output logic                        check_bits_oe_o
);

  adc_state_t                 state;
  adc_state_t                 next_state;
  adc_req_t                   cur;
  adc_req_t                   next_cur;
  logic [`ADC_ROW_W-1:0]      ref_row;
  logic [`ADC_ROW_W-1:0]      next_ref_row;
  logic [`ADC_TMR_W-1:0]      ref_cnt;
  logic [`ADC_TMR_W-1:0]      next_ref_cnt;
  logic [`ADC_TMR_W-1:0]      idle_cnt;
  logic [`ADC_TMR_W-1:0]      next_idle_cnt;
  logic [`ADC_CNT_INIT_W-1:0] init_left;
  logic [`ADC_CNT_INIT_W-1:0] next_init_left;
  logic                       ref_due;
  logic                       next_ref_due;
  adc_pins_t                  next_dram;
  logic                       drive;
  logic                       next_drive;
  logic [`ADC_DATA_W-1:0]     next_data_o;
  logic [`ADC_CHK_W-1:0]      next_check_bits_o;
  adc_rsp_t                   next_rd;
  logic                       next_rd_valid;
  logic                       next_init_done;
  logic [`ADC_DATA_W-1:0]     data_meta;
  logic [`ADC_DATA_W-1:0]     data_sync;
  logic [`ADC_CHK_W-1:0]      chk_meta;
  logic [`ADC_CHK_W-1:0]      chk_sync;
  logic                       tmr_load;
  logic [`ADC_TMR_W-1:0]      tmr_value;
  logic                       tmr_done;
  logic                       page_hit;
  logic                       idle_take;
  logic                       ref_tick;
  logic                       ras_fall;

  // phase length in cycles, loaded as length minus one
  function automatic logic [`ADC_TMR_W-1:0] phase_len(input adc_state_t s);
    int unsigned n;
    n = 1;
    case (s)
      S_PAUSE:                        n = PAUSE_CYC;
      S_ROW, S_COL, S_ROR_SET:        n = T_ASR;
      S_RCD:                          n = T_RCD;
      S_CAS:                          n = T_CAS;
      S_CAS_UP:                       n = T_CP;
      S_PRE, S_HID_PRE:               n = T_RP;
      S_ROR_RAS, S_CBR_RAS, S_HID_RAS: n = T_RAS;
      S_CBR_CAS:                      n = T_CSR;
      default:                        n = 1;
    endcase
    if (n == 0) begin
      n = 1;
    end
    return `ADC_TMR_W'(n - 1);
  endfunction

  adc_tmr u_tmr (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .load_i  (tmr_load),
    .value_i (tmr_value),
    .done_o  (tmr_done)
  );

  // a page continues only for the same bank and row, and never delays a due refresh
  assign page_hit = req_valid_i && page_en_i && !ref_due && (init_left == '0)
                    && (req_i.bank == cur.bank) && (req_i.row == cur.row);
  assign idle_take = (state == S_IDLE) && (init_left == '0)
                     && !(ref_due && refresh_en_i);
  assign req_ready_o = idle_take || ((state == S_CAS_UP) && tmr_done && page_hit);
  assign ref_tick = refresh_en_i && (ref_cnt == `ADC_TMR_W'(REF_CYC - 1));

  always_comb begin
    next_state = state;
    next_cur   = cur;
    if (req_valid_i && req_ready_o) begin
      next_cur = req_i;
    end
    case (state)
      S_BOOT: begin
        next_state = S_PAUSE;
      end
      S_PAUSE: begin
        if (tmr_done) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (init_left != '0) begin
          next_state = S_ROR_SET;
        end else if (ref_due && refresh_en_i) begin
          if (refresh_mode_i == ADC_REF_ROW_ONLY) begin
            next_state = S_ROR_SET;
          end else begin
            next_state = S_CBR_CAS;
          end
        end else if (req_valid_i) begin
          next_state = S_ROW;
        end
      end
      S_ROW:     if (tmr_done) next_state = S_RCD;
      S_RCD:     if (tmr_done) next_state = S_COL;
      S_COL:     if (tmr_done) next_state = S_CAS;
      S_CAS: begin
        if (tmr_done) begin
          if (ref_due && refresh_en_i && refresh_mode_i == ADC_REF_HIDDEN) begin
            next_state = S_HID_PRE;
          end else begin
            next_state = S_CAS_UP;
          end
        end
      end
      S_CAS_UP: begin
        if (tmr_done) begin
          next_state = page_hit ? S_COL : S_PRE;
        end
      end
      S_ROR_SET: if (tmr_done) next_state = S_ROR_RAS;
      S_CBR_CAS: if (tmr_done) next_state = S_CBR_RAS;
      S_HID_PRE: if (tmr_done) next_state = S_HID_RAS;
      S_ROR_RAS, S_CBR_RAS, S_HID_RAS: begin
        if (tmr_done) begin
          next_state = S_PRE;
        end
      end
      S_PRE:     if (tmr_done) next_state = S_IDLE;
      default:   next_state = S_IDLE;
    endcase
  end

  assign tmr_load  = (next_state != state) || (state == S_CAS_UP && next_state == S_COL);
  assign tmr_value = phase_len(next_state);
  assign ras_fall  = (next_state != state) && (next_state == S_RCD
                     || next_state == S_ROR_RAS || next_state == S_CBR_RAS
                     || next_state == S_HID_RAS);

  // refresh spacing, idle watch and wake-up count
  always_comb begin
    next_ref_cnt   = ref_tick || !refresh_en_i ? '0 : ref_cnt + `ADC_TMR_W'(1);
    next_ref_row   = ref_row;
    next_init_left = init_left;
    next_idle_cnt  = idle_cnt;
    // a new tick wins over the clear of the refresh it replaces
    next_ref_due   = ref_tick || (ref_due && !(ras_fall && next_state != S_RCD));
    if (ras_fall) begin
      next_idle_cnt = '0;
      if (next_state != S_RCD && init_left != '0) begin
        next_init_left = init_left - `ADC_CNT_INIT_W'(1);
      end
    end else if (idle_cnt != `ADC_TMR_W'(IDLE_CYC)) begin
      next_idle_cnt = idle_cnt + `ADC_TMR_W'(1);
    end else if (init_left == '0) begin
      next_init_left = `ADC_CNT_INIT_W'(`ADC_INIT_RAS);
      next_idle_cnt  = '0;
    end
    if (state == S_ROR_RAS && next_state == S_PRE) begin
      next_ref_row = ref_row + `ADC_ROW_W'(1);
    end
    next_init_done = (state != S_BOOT) && (state != S_PAUSE) && (next_init_left == '0);
  end

  // pin levels follow the state being entered so every pin comes from a flip-flop
  always_comb begin
    next_dram.ras_n  = 1'b1;
    next_dram.cas_n  = 1'b1;
    next_dram.we_n   = 1'b1;
    next_dram.bank_n = 2'b11;
    next_dram.addr   = dram_o.addr;
    next_drive       = 1'b0;
    next_data_o      = data_o;
    next_check_bits_o = check_bits_o;
    case (next_state)
      S_ROW: begin
        next_dram.addr = `ADC_PIN_A_W'(next_cur.row);
        next_dram.bank_n = next_cur.bank ? 2'b01 : 2'b10;
      end
      S_RCD: begin
        next_dram.ras_n  = 1'b0;
        next_dram.bank_n = cur.bank ? 2'b01 : 2'b10;
      end
      S_COL, S_CAS: begin
        next_dram.ras_n  = 1'b0;
        next_dram.cas_n  = (next_state == S_COL);
        next_dram.bank_n = next_cur.bank ? 2'b01 : 2'b10;
        next_dram.addr   = `ADC_PIN_A_W'(next_cur.col);
        // write enable is settled in the column setup phase, never later
        next_dram.we_n   = !next_cur.write;
        next_drive       = next_cur.write;
        next_data_o       = next_cur.data;
        next_check_bits_o = next_cur.check_bits;
      end
      S_CAS_UP: begin
        next_dram.ras_n  = 1'b0;
        next_dram.bank_n = cur.bank ? 2'b01 : 2'b10;
      end
      S_ROR_SET, S_ROR_RAS: begin
        next_dram.ras_n  = (next_state == S_ROR_SET);
        next_dram.addr   = `ADC_PIN_A_W'(ref_row);
        next_dram.bank_n = 2'b00;
      end
      S_CBR_CAS, S_CBR_RAS: begin
        // address left as is, the module counts rows itself
        next_dram.cas_n  = 1'b0;
        next_dram.ras_n  = (next_state == S_CBR_CAS);
        next_dram.we_n   = 1'b1;
        next_dram.bank_n = 2'b00;
      end
      S_HID_PRE, S_HID_RAS: begin
        next_dram.cas_n  = 1'b0;
        next_dram.ras_n  = (next_state == S_HID_PRE);
        next_dram.we_n   = 1'b1;
        next_dram.bank_n = 2'b00;
      end
      default: begin
      end
    endcase
  end

  // read data is taken on the last cycle of the column strobe from the synchronised pins
  always_comb begin
    next_rd       = rd_o;
    next_rd_valid = 1'b0;
    if (state == S_CAS && tmr_done && !cur.write) begin
      next_rd.data       = data_sync;
      next_rd.check_bits = chk_sync;
      next_rd_valid      = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    data_meta <= data_i;
    data_sync <= data_meta;
    chk_meta  <= check_bits_i;
    chk_sync  <= chk_meta;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state        <= S_BOOT;
      cur          <= '0;
      ref_row      <= '0;
      ref_cnt      <= '0;
      idle_cnt     <= '0;
      init_left    <= `ADC_CNT_INIT_W'(`ADC_INIT_RAS);
      ref_due      <= 1'b0;
      dram_o       <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, bank_n: 2'b11, addr: '0};
      drive        <= 1'b0;
      data_o       <= '0;
      check_bits_o <= '0;
      rd_o         <= '0;
      rd_valid_o   <= 1'b0;
      init_done_o  <= 1'b0;
    end else begin
      state        <= next_state;
      cur          <= next_cur;
      ref_row      <= next_ref_row;
      ref_cnt      <= next_ref_cnt;
      idle_cnt     <= next_idle_cnt;
      init_left    <= next_init_left;
      ref_due      <= next_ref_due;
      dram_o       <= next_dram;
      drive        <= next_drive;
      data_o       <= next_data_o;
      check_bits_o <= next_check_bits_o;
      rd_o         <= next_rd;
      rd_valid_o   <= next_rd_valid;
      init_done_o  <= next_init_done;
    end
  end

  assign data_oe_o       = drive;
  assign check_bits_oe_o = drive;

endmodule

// file: verification/adc_ctrl_asserts.sv
// checker on the strobe pins of the dram controller
// assumes it is bound into adc_ctrl and sees only that module's ports
`include "adc_regs.svh"

module adc_ctrl_asserts
  import adc_pkg::*;
#(
  parameter int unsigned PAUSE_CYC = 20
)
(
  // clock and reset
  input wire logic      clk_i,
  input wire logic      rst_b_i,
  // watched ports
  input wire logic      req_valid_i,
  input wire logic      req_ready_o,
  input wire adc_req_t  req_i,
  input wire logic      init_done_o,
  input wire adc_pins_t dram_o,
  input wire logic      data_oe_o
);
  logic [31:0] cyc;
  logic [31:0] next_cyc;
  logic [3:0]  nras;
  logic [3:0]  next_nras;
  logic        ras_q;
  adc_req_t    held;
  adc_req_t    next_held;

  // saturating counts so a long run never wraps into a false failure
  always_comb begin
    next_cyc  = (cyc == 32'hffff_ffff) ? cyc : cyc + 32'h1;
    next_nras = (ras_q && !dram_o.ras_n && nras != 4'hf) ? nras + 4'h1 : nras;
    next_held = (req_valid_i && req_ready_o) ? req_i : held;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cyc   <= '0;
      nras  <= '0;
      ras_q <= 1'b1;
      held  <= '0;
    end else begin
      cyc   <= next_cyc;
      nras  <= next_nras;
      ras_q <= dram_o.ras_n;
      held  <= next_held;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_pause_first: assert property (
    $fell(dram_o.ras_n) |-> cyc >= PAUSE_CYC) else $error("row strobe inside pause");
  chk_init_eight: assert property (
    $rose(init_done_o) |=> nras >= 4'h8) else $error("init done before eight rows");
  chk_we_late: assert property (
    $fell(dram_o.we_n) |-> dram_o.cas_n) else $error("write enable fell under cas");
  chk_rw_mode: assert property (
    $fell(dram_o.cas_n) && !dram_o.ras_n |-> $stable(dram_o.we_n)
      && (dram_o.we_n != data_oe_o)) else $error("write enable wrong at cas");
  chk_row_addr: assert property (
    $fell(dram_o.ras_n) && dram_o.cas_n && dram_o.bank_n != 2'b00
      |-> dram_o.addr == {1'b0, held.row} && !dram_o.bank_n[held.bank])
    else $error("row address or bank wrong");
  chk_col_addr: assert property (
    $fell(dram_o.cas_n) && !dram_o.ras_n
      |-> dram_o.addr == {1'b0, held.col} && $onehot(~dram_o.bank_n))
    else $error("column address wrong");
  chk_ror_cas: assert property (
    $fell(dram_o.ras_n) && dram_o.cas_n && dram_o.bank_n == 2'b00
      |=> dram_o.cas_n [*4]) else $error("cas fell in row-only refresh");
  chk_cbr_we: assert property (
    !dram_o.cas_n && dram_o.bank_n == 2'b00 |-> dram_o.we_n)
    else $error("write enable low in refresh");
  chk_hid_we: assert property (
    $fell(dram_o.ras_n) && !dram_o.cas_n |-> dram_o.we_n && $past(dram_o.we_n))
    else $error("write enable low before refresh row strobe");
endmodule

bind adc_ctrl adc_ctrl_asserts #(.PAUSE_CYC(PAUSE_CYC)) u_chk (
  .clk_i       (clk_i),
  .rst_b_i     (rst_b_i),
  .req_valid_i (req_valid_i),
  .req_ready_o (req_ready_o),
  .req_i       (req_i),
  .init_done_o (init_done_o),
  .dram_o      (dram_o),
  .data_oe_o   (data_oe_o)
);

// file: verification/adc_dram_model.sv
// behavioural dram module answering the controller's strobes
// assumes strobes move only at controller clock edges
`include "adc_regs.svh"

module adc_dram_model
  import adc_pkg::*;
(
  // answer speed, strobes and write data
  input  wire logic      slow_i,
  input  wire adc_pins_t pins_i,
  input  wire adc_rsp_t  wr_i,
  // read data towards the controller
  output adc_rsp_t       rd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  adc_rsp_t                mem [bit [22:0]];
  logic [`ADC_ROW_W-1:0]   row;
  logic                    bnk;
  logic [22:0]             key;
  int                      ror_cnt;
  int                      cbr_cnt;

  initial begin
    rd_o    = '0;
    row     = '0;
    bnk     = 1'b0;
    ror_cnt = 0;
    cbr_cnt = 0;
  end

  always @(negedge pins_i.ras_n) begin
    if (pins_i.cas_n) begin
      row = pins_i.addr[`ADC_ROW_W-1:0];
      bnk = !pins_i.bank_n[1];
      if (pins_i.bank_n == 2'b00) ror_cnt++;
    end else begin
      // address ignored and outputs left as they were
      cbr_cnt++;
    end
  end

  always @(negedge pins_i.cas_n) begin
    if (!pins_i.ras_n) begin
      key = {bnk, row, pins_i.addr[`ADC_COL_W-1:0]};
      if (!pins_i.we_n) begin
        mem[key] = wr_i;
      end else begin
        #(slow_i ? 8 : 2);
        rd_o = mem.exists(key) ? mem[key] : '0;
      end
    end
  end

  // released lines flip so a stale value can never be read as good
  always @(posedge pins_i.cas_n) begin
    rd_o = ~rd_o;
  end
endmodule

// file: verification/test_async_dram_module_cycles.sv
// self-checking bench: controller against a behavioural dram module
// assumes shortened pause, idle and refresh counts
`include "adc_regs.svh"

module test_async_dram_module_cycles
  import adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   clk_i;
  logic                   rst_b_i;
  logic                   req_valid_i;
  logic                   req_ready_o;
  adc_req_t               req_i;
  logic                   page_en_i;
  logic                   rd_valid_o;
  adc_rsp_t               rd_o;
  logic                   refresh_en_i;
  adc_ref_mode_t          refresh_mode_i;
  logic                   init_done_o;
  adc_pins_t              dram_o;
  adc_rsp_t               mrd;
  logic [`ADC_DATA_W-1:0] data_o;
  logic [`ADC_CHK_W-1:0]  check_bits_o;
  logic                   dat_oe;
  logic                   chk_oe;
  logic                   slow;
  logic [31:0]            seed;
  logic [31:0]            a [8];
  adc_rsp_t               ref_mem [bit [22:0]];
  logic [143:0]           expq [$];
  int                     bad_count;
  int                     checked;
  int                     cyc;
  int                     nras;
  int                     i;
  int                     n;
  int                     d;

  adc_ctrl #(.PAUSE_CYC(20), .IDLE_CYC(200), .REF_CYC(100)) DUT (
    .clk_i           (clk_i),
    .rst_b_i         (rst_b_i),
    .req_valid_i     (req_valid_i),
    .req_ready_o     (req_ready_o),
    .req_i           (req_i),
    .page_en_i       (page_en_i),
    .rd_valid_o      (rd_valid_o),
    .rd_o            (rd_o),
    .refresh_en_i    (refresh_en_i),
    .refresh_mode_i  (refresh_mode_i),
    .init_done_o     (init_done_o),
    .dram_o          (dram_o),
    .data_i          (mrd.data),
    .data_o          (data_o),
    .data_oe_o       (dat_oe),
    .check_bits_i    (mrd.check_bits),
    .check_bits_o    (check_bits_o),
    .check_bits_oe_o (chk_oe)
  );

  adc_dram_model mdl (
    .slow_i (slow),
    .pins_i (dram_o),
    .wr_i   ({data_o, check_bits_o}),
    .rd_o   (mrd)
  );

  always #5 clk_i = ~clk_i;

  always @(negedge dram_o.ras_n) nras++;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [143:0] seen, input logic [143:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // entered at a rising edge; leaves valid high so page hits can follow at once
  task automatic issue(input logic wr, input logic [22:0] ad);
    adc_req_t    q;
    logic [31:0] t;
    int          k;
    t = rnd();
    q = '{wr, ad[22], ad[21:11], ad[10:0], {rnd(), rnd(), rnd(), rnd()}, t[15:0]};
    if (wr) ref_mem[ad] = {q.data, q.check_bits};
    else expq.push_back(ref_mem.exists(ad) ? ref_mem[ad] : '0);
    slow <= t[16];
    req_valid_i <= 1'b1;
    req_i <= q;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (req_ready_o !== 1'b1 && k < 2000);
    check(144'(k >= 2000), 144'h0);
    @(posedge clk_i);
  endtask

  task automatic drain(input string name);
    int k;
    req_valid_i <= 1'b0;
    k = 0;
    while (expq.size() != 0 && k < 500) begin
      @(posedge clk_i);
      k++;
    end
    check(144'(expq.size()), 144'h0);
    $display("test %s done", name);
  endtask

  // read answers are compared in the order they were asked for
  always @(negedge clk_i) begin
    if (rd_valid_o === 1'b1) begin
      if (expq.size() == 0) check(144'h1, 144'h0);
      else check(rd_o, expq.pop_front());
    end
    // while both strobes are low, data pins are driven exactly when write enable is low
    if (dram_o.cas_n === 1'b0 && dram_o.ras_n === 1'b0) begin
      check(144'({dat_oe, chk_oe}), 144'({2{!dram_o.we_n}}));
    end
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    page_en_i = 1'b0;
    refresh_en_i = 1'b0;
    refresh_mode_i = ADC_REF_ROW_ONLY;
    slow = 1'b0;
    seed = 32'hfbe4_47dc;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    n = 0;
    while (init_done_o !== 1'b1 && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    check(144'(nras), 144'h8);
    $display("test init done");
    for (i = 0; i < 16; i++) begin
      if (i < 8) a[i] = rnd();
      issue(i < 8, a[i % 8][22:0]);
    end
    drain("random");
    page_en_i <= 1'b1;
    for (i = 0; i < 10; i++) begin
      // top row and columns at the edge of the page, mixed reads and writes
      issue(i < 4 || i == 6, {1'b1, 11'h7ff, 11'h7fc + 11'(i % 4)});
    end
    drain("page");
    page_en_i <= 1'b0;
    refresh_en_i <= 1'b1;
    for (i = 0; i < 3; i++) begin
      refresh_mode_i <= adc_ref_mode_t'(i);
      d = (i == 0) ? mdl.ror_cnt : mdl.cbr_cnt;
      for (n = 0; n < 16; n++) issue(1'b0, a[n % 8][22:0]);
      drain("refresh");
      d = ((i == 0) ? mdl.ror_cnt : mdl.cbr_cnt) - d;
      check(144'(d > 0), 144'h1);
    end
    refresh_en_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    n = nras;
    repeat (300) @(posedge clk_i);
    check(144'(nras - n), 144'h8);
    issue(1'b0, a[3][22:0]);
    drain("wake");
    final_report();
  end
endmodule
